// File: rtl/handshake_status_and_irq_clear.sv
// Handshake status word, terminal count flags and interrupt clear registers
`timescale 1ns/100ps
`include "hs_status_map.svh"

module handshake_status_and_irq_clear #(
	parameter bit REV_OLDER = 1'b0
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Register port
	input wire logic [`HS_ADDR_W-1:0] i_addr,
	input wire logic [`HS_DATA_W-1:0] i_wr_data,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	output logic [`HS_DATA_W-1:0] o_rd_data,
	// Connector lines
	input wire hs_status_pkg::hs_lines_s i_group1_lines,
	input wire hs_status_pkg::hs_lines_s i_group2_lines,
	input wire logic i_extra_input_one,
	input wire logic i_extra_input_two,
	// Readiness sources
	input wire hs_status_pkg::group_ready_s i_group1_ready_src,
	input wire hs_status_pkg::group_ready_s i_group2_ready_src,
	// DMA and counter events
	input wire hs_status_pkg::dma_tc_s i_dma_tc,
	input wire logic i_counter3_out,
	// Interrupts
	output logic o_irq,
	output logic o_irq_group1,
	output logic o_irq_group2,
	// Counter gates and DMA channel select
	output logic o_counter_one_gate,
	output logic o_counter_two_gate,
	output logic o_dma_channel_sel
);
	import hs_status_pkg::*;

	// ====================================================================
	// State
	localparam bank_state_s STATE_RST = '{
		chan: CHAN_OWN,
		cnt_flag: 1'b0,
		g1_tc_flag: 1'b0,
		g2_tc_flag: 1'b0,
		cnt3_prev: 1'b0,
		irq_en: `HS_IRQ_EN_RST,
		ctrl: `HS_CTRL_RST,
		rd_data: `HS_ZERO_WORD,
		irq: 1'b0,
		irq_g1: 1'b0,
		irq_g2: 1'b0,
		gate_one: 1'b0,
		gate_two: 1'b0,
		dma_sel: 1'b0
	};

	bank_state_s state_r;
	bank_state_s state_nxt;

	// Decoded strobes and events
	logic wr_cnt_clr;
	logic wr_g1_clr;
	logic wr_g2_clr;
	logic dual_mode;
	logic cnt3_rise;
	logic tc_active;
	logic g1_tc_evt;
	logic g2_tc_evt;
	logic cnt_evt;
	logic g1_ready;
	logic g2_ready;
	logic [`HS_DATA_W-1:0] status_word;

	// Address decode of the write strobes
	assign wr_cnt_clr = i_wr_en && (i_addr == `HS_OFF_CNT_CLR);
	assign wr_g1_clr = i_wr_en && (i_addr == `HS_OFF_G1_CLR);
	assign wr_g2_clr = i_wr_en && (i_addr == `HS_OFF_G2_CLR);

	// Event detection
	assign dual_mode = state_r.ctrl[`HS_CTL_DUAL];
	assign cnt3_rise = i_counter3_out && !state_r.cnt3_prev;
	assign cnt_evt = cnt3_rise && state_r.irq_en[`HS_BIT_CNT];
	assign tc_active = (state_r.chan == CHAN_OWN) ? i_dma_tc.chan_one : i_dma_tc.chan_two;

	// In dual mode both channels serve group one
	assign g1_tc_evt = dual_mode ? tc_active : i_dma_tc.chan_one;
	assign g2_tc_evt = !dual_mode && i_dma_tc.chan_two;

	// Group readiness by direction
	assign g1_ready = state_r.ctrl[`HS_CTL_G1_WR] ? i_group1_ready_src.sink_ready
		: (state_r.ctrl[`HS_CTL_G1_HS] && i_group1_ready_src.data_avail);
	assign g2_ready = state_r.ctrl[`HS_CTL_G2_WR] ? i_group2_ready_src.sink_ready
		: (state_r.ctrl[`HS_CTL_G2_HS] && i_group2_ready_src.data_avail);

	// ====================================================================
	// Status word assembly
	always_comb
	begin
		status_word = `HS_ZERO_WORD;
		status_word[`HS_BIT_CHAN] = dual_mode && (state_r.chan == CHAN_OTHER);
		status_word[`HS_BIT_CNT] = state_r.cnt_flag;
		status_word[`HS_BIT_WIDE] = state_r.ctrl[`HS_CTL_WIDE];
		status_word[`HS_BIT_EXTRA_ONE] = i_extra_input_one;
		status_word[`HS_BIT_TC2] = state_r.g2_tc_flag;
		status_word[`HS_BIT_TC1] = state_r.g1_tc_flag;
		status_word[`HS_BIT_RDY1] = g1_ready;
		status_word[`HS_BIT_G1_REQ] = i_group1_lines.request;
		status_word[`HS_BIT_G1_ACK] = i_group1_lines.acknowledge;
		status_word[`HS_BIT_EXTRA_TWO] = i_extra_input_two;
		status_word[`HS_BIT_REV] = REV_OLDER;
		status_word[`HS_BIT_RDY2] = g2_ready;
		status_word[`HS_BIT_G2_REQ] = i_group2_lines.request;
		status_word[`HS_BIT_G2_ACK] = i_group2_lines.acknowledge;
	end

	// ====================================================================
	// Next state
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.cnt3_prev = i_counter3_out;

		// Channel alternation in dual mode
		if (!dual_mode)
		begin
			state_nxt.chan = CHAN_OWN;
		end
		else if (tc_active)
		begin
			case (state_r.chan)
				CHAN_OWN: state_nxt.chan = CHAN_OTHER;
				CHAN_OTHER: state_nxt.chan = CHAN_OWN;
				default: state_nxt.chan = CHAN_OWN;
			endcase
		end

		// Sticky flags, set wins over clear
		if (cnt_evt)
		begin
			state_nxt.cnt_flag = 1'b1;
		end
		else if (wr_cnt_clr)
		begin
			state_nxt.cnt_flag = 1'b0;
		end
		if (g1_tc_evt)
		begin
			state_nxt.g1_tc_flag = 1'b1;
		end
		else if (wr_g1_clr)
		begin
			state_nxt.g1_tc_flag = 1'b0;
		end
		if (g2_tc_evt)
		begin
			state_nxt.g2_tc_flag = 1'b1;
		end
		else if (wr_g2_clr)
		begin
			state_nxt.g2_tc_flag = 1'b0;
		end

		// Writable configuration; status offset ignores writes
		if (i_wr_en && (i_addr == `HS_OFF_IRQ_EN))
		begin
			state_nxt.irq_en = i_wr_data & `HS_IRQ_EN_MASK;
		end
		if (i_wr_en && (i_addr == `HS_OFF_CTRL))
		begin
			state_nxt.ctrl = i_wr_data[`HS_CTRL_W-1:0];
		end

		// Read data, zero for write-only and unmapped offsets
		state_nxt.rd_data = `HS_ZERO_WORD;
		if (i_rd_en)
		begin
			case (i_addr)
				`HS_OFF_STATUS: state_nxt.rd_data = status_word;
				`HS_OFF_IRQ_EN: state_nxt.rd_data = state_r.irq_en;
				`HS_OFF_CTRL: state_nxt.rd_data = {8'h00, state_r.ctrl};
				default: state_nxt.rd_data = `HS_ZERO_WORD;
			endcase
		end

		// Interrupt lines from the updated flags
		state_nxt.irq_g1 = state_nxt.g1_tc_flag && state_nxt.irq_en[`HS_BIT_TC1];
		state_nxt.irq_g2 = state_nxt.cnt_flag
			|| (state_nxt.g2_tc_flag && state_nxt.irq_en[`HS_BIT_TC2]);
		state_nxt.irq = state_nxt.irq_g1 || state_nxt.irq_g2;

		// Counter gates and channel select
		state_nxt.gate_one = state_r.ctrl[`HS_CTL_C1EN] && i_extra_input_one;
		state_nxt.gate_two = state_r.ctrl[`HS_CTL_C2EN] && i_extra_input_two;
		state_nxt.dma_sel = dual_mode && (state_nxt.chan == CHAN_OTHER);
	end

	// State register
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_r <= STATE_RST;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from the state register
	assign o_rd_data = state_r.rd_data;
	assign o_irq = state_r.irq;
	assign o_irq_group1 = state_r.irq_g1;
	assign o_irq_group2 = state_r.irq_g2;
	assign o_counter_one_gate = state_r.gate_one;
	assign o_counter_two_gate = state_r.gate_two;
	assign o_dma_channel_sel = state_r.dma_sel;

	// ====================================================================
	// Assertions
	default clocking cb_sys @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	// Read of the status offset
	sequence s_stat_rd;
		i_rd_en && (i_addr == `HS_OFF_STATUS);
	endsequence

	// Counter event then counter flag set on the next cycle
	sequence s_cnt_set;
		cnt_evt ##1 state_r.cnt_flag;
	endsequence

	// Terminal count on the channel in use during dual mode
	sequence s_dual_tc;
		dual_mode && tc_active;
	endsequence

	// Status writes leave flags alone
	a_status_write_inert:
	assert property ((i_wr_en && i_addr == `HS_OFF_STATUS && !cnt_evt && !g1_tc_evt
		&& !g2_tc_evt) |=> $stable(state_r.cnt_flag) && $stable(state_r.g1_tc_flag)
		&& $stable(state_r.g2_tc_flag))
	else $error("status write changed a flag");

	a_chan_bit_read:
	assert property (s_stat_rd |=> o_rd_data[`HS_BIT_CHAN]
		== ($past(dual_mode) && $past(state_r.chan) == CHAN_OTHER))
	else $error("channel bit does not match channel in use");

	a_chan_swap:
	assert property (s_dual_tc |=> (state_r.chan != $past(state_r.chan))
		##1 (o_dma_channel_sel == (state_r.chan == CHAN_OTHER) || !dual_mode))
	else $error("channel did not swap on terminal count");

	a_chan_hold:
	assert property ((dual_mode && !tc_active) |=> $stable(state_r.chan))
	else $error("channel changed without terminal count");

	a_cnt_set_hold:
	assert property (s_cnt_set ##0 (!wr_cnt_clr)[*2] |=> state_r.cnt_flag)
	else $error("counter flag not sticky");

	a_cnt_no_enable:
	assert property ((cnt3_rise && !state_r.irq_en[`HS_BIT_CNT] && !state_r.cnt_flag)
		|=> !state_r.cnt_flag)
	else $error("counter flag set while disabled");

	a_cnt_clear:
	assert property ((wr_cnt_clr && !cnt_evt) |=> !state_r.cnt_flag
		&& (!o_irq_group2 || state_r.g2_tc_flag))
	else $error("counter clear write ignored");

	a_cnt_on_group2:
	assert property (state_r.cnt_flag |-> o_irq_group2 && o_irq)
	else $error("counter request missing on group two line");

	a_wide_bit:
	assert property (s_stat_rd |=> o_rd_data[`HS_BIT_WIDE] == $past(state_r.ctrl[`HS_CTL_WIDE]))
	else $error("wide transfer bit wrong");

	a_gate_one:
	assert property (##1 o_counter_one_gate
		== ($past(state_r.ctrl[`HS_CTL_C1EN]) && $past(i_extra_input_one)))
	else $error("counter one gate wrong");

	a_gate_two:
	assert property (##1 o_counter_two_gate
		== ($past(state_r.ctrl[`HS_CTL_C2EN]) && $past(i_extra_input_two)))
	else $error("counter two gate wrong");

	a_extra_inputs:
	assert property (s_stat_rd |=> o_rd_data[`HS_BIT_EXTRA_TWO] == $past(i_extra_input_two)
		&& o_rd_data[`HS_BIT_EXTRA_ONE] == $past(i_extra_input_one))
	else $error("extra input bits wrong");

	a_tc2_clear:
	assert property ((wr_g2_clr && !g2_tc_evt) |=> !state_r.g2_tc_flag)
	else $error("group two flag not cleared");

	a_tc2_set:
	assert property (g2_tc_evt |=> state_r.g2_tc_flag)
	else $error("group two flag not set");

	a_tc2_irq:
	assert property ((g2_tc_evt && state_r.irq_en[`HS_BIT_TC2]
		&& !(i_wr_en && i_addr == `HS_OFF_IRQ_EN)) |=> o_irq_group2 && o_irq)
	else $error("group two request missing");

	a_tc1_set:
	assert property (g1_tc_evt |=> state_r.g1_tc_flag)
	else $error("group one flag not set");

	a_tc1_clear:
	assert property ((wr_g1_clr && !g1_tc_evt) |=> !state_r.g1_tc_flag && !o_irq_group1)
	else $error("group one flag not cleared");

	a_tc_irq:
	assert property ((g1_tc_evt && state_r.irq_en[`HS_BIT_TC1]
		&& !(i_wr_en && i_addr == `HS_OFF_IRQ_EN)) |=> o_irq_group1 && o_irq)
	else $error("group one request missing");

	a_ready_one:
	assert property (s_stat_rd |=> o_rd_data[`HS_BIT_RDY1] == $past(g1_ready))
	else $error("group one ready wrong");

	a_ready_two:
	assert property ((s_stat_rd and state_r.ctrl[`HS_CTL_G2_WR])
		|=> o_rd_data[`HS_BIT_RDY2] == $past(i_group2_ready_src.sink_ready))
	else $error("group two ready wrong");

	a_lines_one:
	assert property (s_stat_rd |=> o_rd_data[`HS_BIT_G1_REQ:`HS_BIT_G1_ACK]
		== $past({i_group1_lines.request, i_group1_lines.acknowledge}))
	else $error("group one lines wrong");

	a_lines_two:
	assert property (s_stat_rd |=> o_rd_data[`HS_BIT_G2_REQ:`HS_BIT_G2_ACK]
		== $past({i_group2_lines.request, i_group2_lines.acknowledge}))
	else $error("group two lines wrong");

	a_rev_bit:
	assert property (s_stat_rd |=> o_rd_data[`HS_BIT_REV] == REV_OLDER)
	else $error("revision bit wrong");

	a_unmapped_zero:
	assert property ((i_rd_en && i_addr != `HS_OFF_STATUS && i_addr != `HS_OFF_IRQ_EN
		&& i_addr != `HS_OFF_CTRL) |=> o_rd_data == `HS_ZERO_WORD)
	else $error("unmapped read not zero");

	a_read_one_cycle:
	assert property (!i_rd_en |=> o_rd_data == `HS_ZERO_WORD)
	else $error("read data outside answer cycle");
endmodule

// File: include/hs_status_map.svh
// Offsets, field positions and reset values of the handshake status bank
`ifndef HS_STATUS_MAP_SVH
`define HS_STATUS_MAP_SVH

// ====================================================================
// Bus widths
`define HS_ADDR_W 5
`define HS_DATA_W 16
`define HS_CTRL_W 8

// ====================================================================
// Register offsets
`define HS_OFF_STATUS 5'h00
`define HS_OFF_CNT_CLR 5'h0a
`define HS_OFF_G1_CLR 5'h0c
`define HS_OFF_G2_CLR 5'h0e
`define HS_OFF_IRQ_EN 5'h12
`define HS_OFF_CTRL 5'h16

// ====================================================================
// Status word fields
`define HS_BIT_CHAN 15
`define HS_BIT_CNT 14
`define HS_BIT_WIDE 12
`define HS_BIT_EXTRA_ONE 11
`define HS_BIT_TC2 10
`define HS_BIT_TC1 9
`define HS_BIT_RDY1 8
`define HS_BIT_G1_REQ 7
`define HS_BIT_G1_ACK 6
`define HS_BIT_EXTRA_TWO 5
`define HS_BIT_REV 4
`define HS_BIT_RDY2 2
`define HS_BIT_G2_REQ 1
`define HS_BIT_G2_ACK 0

// ====================================================================
// Control register fields
`define HS_CTL_DUAL 0
`define HS_CTL_C1EN 1
`define HS_CTL_C2EN 2
`define HS_CTL_WIDE 3
`define HS_CTL_G1_WR 4
`define HS_CTL_G1_HS 5
`define HS_CTL_G2_WR 6
`define HS_CTL_G2_HS 7

// ====================================================================
// Reset values and masks
`define HS_IRQ_EN_MASK 16'h4600
`define HS_IRQ_EN_RST 16'h0000
`define HS_CTRL_RST 8'h00
`define HS_ZERO_WORD 16'h0000

`endif

// File: include/hs_status_pkg.sv
// Types shared by the handshake status bank
package hs_status_pkg;
`include "hs_status_map.svh"

	// Which DMA channel carries group one traffic
	typedef enum logic [1:0] {
		CHAN_OWN = 2'b01,
		CHAN_OTHER = 2'b10
	} dma_chan_e;

	// Connector handshake lines of one group
	typedef struct packed {
		logic request;
		logic acknowledge;
	} hs_lines_s;

	// Readiness sources of one group
	typedef struct packed {
		logic data_avail;
		logic sink_ready;
	} group_ready_s;

	// Terminal count pulses of the two DMA channels
	typedef struct packed {
		logic chan_one;
		logic chan_two;
	} dma_tc_s;

	// Whole state of the bank
	typedef struct packed {
		dma_chan_e chan;
		logic cnt_flag;
		logic g1_tc_flag;
		logic g2_tc_flag;
		logic cnt3_prev;
		logic [`HS_DATA_W-1:0] irq_en;
		logic [`HS_CTRL_W-1:0] ctrl;
		logic [`HS_DATA_W-1:0] rd_data;
		logic irq;
		logic irq_g1;
		logic irq_g2;
		logic gate_one;
		logic gate_two;
		logic dma_sel;
	} bank_state_s;
endpackage

// File: dv/ext_handshake_dev.sv
// Model of the external device on the connector side of the status bank
`timescale 1ns/100ps

// ====================================================================
// External device model
module ext_handshake_dev
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Commands from the bench
	input wire logic [9:0] i_level,
	input wire logic [1:0] i_tc_go,
	input wire logic i_cnt3_level,
	// Connector and event side
	output hs_status_pkg::hs_lines_s o_group1_lines,
	output hs_status_pkg::hs_lines_s o_group2_lines,
	output logic o_extra_input_one,
	output logic o_extra_input_two,
	output hs_status_pkg::group_ready_s o_group1_ready_src,
	output hs_status_pkg::group_ready_s o_group2_ready_src,
	output hs_status_pkg::dma_tc_s o_dma_tc,
	output logic o_counter3_out
);
	import hs_status_pkg::*;

	// Drive lines after each edge; extra inputs float to their pull-up in reset
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_group1_lines <= '0;
			o_group2_lines <= '0;
			o_extra_input_one <= 1'b1;
			o_extra_input_two <= 1'b1;
			o_group1_ready_src <= '0;
			o_group2_ready_src <= '0;
			o_dma_tc <= '0;
			o_counter3_out <= 1'b0;
		end
		else
		begin
			o_group1_lines <= {i_level[3], i_level[2]};
			o_group2_lines <= {i_level[1], i_level[0]};
			o_extra_input_one <= i_level[4];
			o_extra_input_two <= i_level[5];
			o_group1_ready_src <= {i_level[6], i_level[7]};
			o_group2_ready_src <= {i_level[8], i_level[9]};
			o_dma_tc <= i_tc_go; // One-cycle pulses
			o_counter3_out <= i_cnt3_level;
		end
	end
endmodule

// File: dv/tb.sv
// Self-checking bench for the handshake status bank
`timescale 1ns/100ps
`include "hs_status_map.svh"

// ====================================================================
// Bench top
module tb;
	import hs_status_pkg::*;
	logic clk_sys, rst_n, wr_en, rd_en, cnt3, cnt3_out, in_one, in_two;
	logic [4:0] addr;
	logic [15:0] wr_data, rd_data, word;
	logic [9:0] level;
	logic [7:0] ctl;
	logic [1:0] tc_go;
	logic irq, irq_g1, irq_g2, gate_one, gate_two, chan_sel;
	hs_lines_s g1_lines, g2_lines;
	group_ready_s g1_rdy, g2_rdy;
	dma_tc_s dma_tc;
	int err_total;
	int compares;
	logic [9:0] pats [5] = '{10'h3ff, 10'h155, 10'h2aa, 10'h0cf, 10'h030};
	logic [7:0] ctls [5] = '{8'hfe, 8'ha6, 8'h58, 8'hb0, 8'h0e};

	// Device and far-side model
	handshake_status_and_irq_clear #(.REV_OLDER(1'b0)) i_dut (.i_clk_sys(clk_sys),
		.i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wr_data), .i_wr_en(wr_en),
		.i_rd_en(rd_en), .o_rd_data(rd_data), .i_group1_lines(g1_lines),
		.i_group2_lines(g2_lines), .i_extra_input_one(in_one), .i_extra_input_two(in_two),
		.i_group1_ready_src(g1_rdy), .i_group2_ready_src(g2_rdy), .i_dma_tc(dma_tc),
		.i_counter3_out(cnt3_out), .o_irq(irq), .o_irq_group1(irq_g1),
		.o_irq_group2(irq_g2), .o_counter_one_gate(gate_one),
		.o_counter_two_gate(gate_two), .o_dma_channel_sel(chan_sel));
	ext_handshake_dev i_dev (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_level(level),
		.i_tc_go(tc_go), .i_cnt3_level(cnt3), .o_group1_lines(g1_lines),
		.o_group2_lines(g2_lines), .o_extra_input_one(in_one),
		.o_extra_input_two(in_two), .o_group1_ready_src(g1_rdy),
		.o_group2_ready_src(g2_rdy), .o_dma_tc(dma_tc), .o_counter3_out(cnt3_out));

	// Clock
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ====================================================================
	// Tasks
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Expected status from live levels, control and event bits
	function automatic logic [15:0] st_exp(input logic [15:0] ev);
		logic r1;
		logic r2;
		r1 = ctl[4] ? level[7] : (ctl[5] & level[6]);
		r2 = ctl[6] ? level[9] : (ctl[7] & level[8]);
		st_exp = ev | {3'h0, ctl[3], level[4], 2'h0, r1, level[3], level[2], level[5],
			2'h0, r2, level[1], level[0]};
	endfunction

	task automatic chk_stat(input logic [15:0] ev);
		rd(`HS_OFF_STATUS, word);
		chk("status", word & 16'hdff7, st_exp(ev));
	endtask

	task automatic chk_irq(input logic [2:0] exp);
		#1;
		chk("irq", {13'h0, irq, irq_g1, irq_g2}, {13'h0, exp});
	endtask

	task automatic tc(input logic [1:0] v);
		@(posedge clk_sys);
		tc_go <= v;
		@(posedge clk_sys);
		tc_go <= 2'b00;
		idle(2);
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		#200000;
		err_total++;
		end_sim();
	end

	// ====================================================================
	// Test sequence
	initial
	begin
		rst_n = 1'b0;
		addr = '0;
		wr_data = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		level = 10'h030;
		tc_go = 2'b00;
		cnt3 = 1'b0;
		ctl = 8'h00;
		err_total = 0;
		compares = 0;
		idle(5);
		rst_n <= 1'b1;
		chk_irq(3'b000);
		chk_stat(16'h0000);
		rd(5'h04, word);
		chk("unmapped", word, 16'h0000);
		rd(`HS_OFF_CNT_CLR, word);
		chk("clear reg", word, 16'h0000);
		$display("test reset done");
		// Live lines, ready, wide flag and counter gates over a table
		for (int i = 0; i < 5; i++)
		begin
			level <= pats[i];
			ctl = ctls[i];
			wr(`HS_OFF_CTRL, {8'h00, ctls[i]});
			idle(2);
			chk_stat(16'h0000);
			chk("gates", {14'h0, gate_one, gate_two},
				{14'h0, ctl[1] & level[4], ctl[2] & level[5]});
		end
		wr(`HS_OFF_STATUS, 16'hffff);
		chk_stat(16'h0000);
		$display("test live lines done");
		// Terminal count flags and their interrupt requests
		wr(`HS_OFF_IRQ_EN, 16'hffff);
		rd(`HS_OFF_IRQ_EN, word);
		chk("irq enable", word, 16'h4600);
		wr(`HS_OFF_IRQ_EN, 16'h0600);
		tc(2'b10);
		chk_stat(16'h0200);
		chk_irq(3'b110);
		wr(`HS_OFF_G1_CLR, 16'h0000);
		chk_irq(3'b000);
		tc(2'b01);
		chk_stat(16'h0400);
		chk_irq(3'b101);
		wr(`HS_OFF_G2_CLR, 16'hffff);
		chk_stat(16'h0000);
		wr(`HS_OFF_IRQ_EN, 16'h0000);
		tc(2'b11);
		chk_stat(16'h0600);
		chk_irq(3'b000);
		wr(`HS_OFF_G1_CLR, 16'h0000);
		wr(`HS_OFF_G2_CLR, 16'h0000);
		$display("test terminal count done");
		// Counter three flag: gated by its enable, sticky, cleared by any write to its clear offset
		cnt3 <= 1'b1;
		idle(3);
		chk_stat(16'h0000);
		cnt3 <= 1'b0;
		wr(`HS_OFF_IRQ_EN, 16'h4000);
		cnt3 <= 1'b1;
		idle(3);
		cnt3 <= 1'b0;
		idle(3);
		chk_stat(16'h4000);
		chk_irq(3'b101);
		wr(`HS_OFF_CNT_CLR, 16'hffff);
		chk_irq(3'b000);
		chk_stat(16'h0000);
		$display("test counter done");
		// Dual channel mode alternation
		ctl = 8'h01;
		wr(`HS_OFF_CTRL, 16'h0001);
		chk_stat(16'h0000);
		tc(2'b01);
		chk_stat(16'h0000);
		tc(2'b10);
		chk_stat(16'h8200);
		chk("channel sel", {15'h0, chan_sel}, 16'h0001);
		tc(2'b01);
		chk_stat(16'h0200);
		chk("channel sel", {15'h0, chan_sel}, 16'h0000);
		$display("test dual channel done");
		// Mid-run reset clears flags, control and channel
		rst_n <= 1'b0;
		ctl = 8'h00;
		idle(2);
		rst_n <= 1'b1;
		chk_irq(3'b000);
		chk_stat(16'h0000);
		$display("test mid-run reset done");
		end_sim();
	end
endmodule
